/* File: bench/tpi_far_end.sv */
// Far-end model: external MAC or PHY driving the inbound pins
`timescale 1ns/10ps
module tpi_far_end (
	input wire logic rmii,
	input wire logic slow,
	output logic lclk,
	output logic sw_tx_enable_pin,
	output logic sw_tx_error_pin,
	output logic [3:0] sw_tx_data_pins
);
	initial begin
		lclk = 1'b0;
		sw_tx_enable_pin = 1'b0;
		sw_tx_error_pin = 1'b0;
		sw_tx_data_pins = 4'h0;
	end
	// Free-running link clock, unrelated in phase to clk
	always #62.5 lclk = ~lclk;
	// Change on the falling edge so the unit is settled at the rising one
	task automatic send(input logic en, input logic err, input logic [3:0] d);
		@(negedge lclk);
		sw_tx_enable_pin = en;
		sw_tx_error_pin = err;
		sw_tx_data_pins = rmii ? {2'b00, d[1:0]} : d;
		repeat (slow ? 9 : 0) @(negedge lclk);
	endtask
endmodule // tpi_far_end

/* File: bench/tpi_port_tb.sv */
// Self-checking bench for the third-port media interface
`timescale 1ns/10ps
module tpi_port_tb;
	import tpi_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic speed_100, half_duplex, mac_tx_busy, rmii, slow, lclk;
	logic tx_en, tx_er, rxv, colp, crsp, mac_rx_drop, mac_col, mac_crs;
	logic [3:0] tx_d, rxd;
	tpi_mode_t mode;
	tpi_nib_t mac_tx, mac_rx;
	logic [3:0] got[$];
	logic [3:0] exp_q[$];
	int drops, seed = 51, failures = 0, check_count = 0;

	always #5 clk = ~clk;

	tpi_far_end far (.rmii(rmii), .slow(slow), .lclk(lclk), .sw_tx_enable_pin(tx_en),
		.sw_tx_error_pin(tx_er), .sw_tx_data_pins(tx_d));

	tpi_port dut (.clk(clk), .srst(srst), .mode(mode), .speed_100(speed_100),
		.half_duplex(half_duplex), .mac_tx(mac_tx), .mac_tx_busy(mac_tx_busy),
		.mac_rx(mac_rx), .mac_rx_drop(mac_rx_drop), .mac_col(mac_col), .mac_crs(mac_crs),
		.sw_tx_enable_pin(tx_en), .sw_tx_error_pin(tx_er), .sw_tx_data_pins(tx_d),
		.sw_tx_clock_pin(lclk), .sw_rx_valid_pin(rxv), .sw_rx_data_pins(rxd),
		.sw_rx_clock_pin(lclk), .sw_ref_clock_pin(lclk), .sw_collision_pin(colp),
		.sw_carrier_pin(crsp));

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	always @(posedge clk) begin
		if (mac_rx.en === 1'b1) begin
			got.push_back(mac_rx.data);
			chk(8'(mac_rx.err), 8'h00);
		end
		if (mac_rx_drop === 1'b1) drops++;
	end

	function automatic logic [3:0] pair_up(input logic [1:0] a, input logic [1:0] b);
		return {b, a};
	endfunction

	// One frame of n units, error flagged on unit bad_at (negative: clean)
	task automatic frame(input int n, input int bad_at);
		logic [3:0] u;
		logic [1:0] prev;
		got.delete();
		exp_q.delete();
		drops = 0;
		for (int i = 0; i < n; i++) begin
			u = (i == 0) ? 4'hf : 4'($random(seed));
			far.send(1'b1, i == bad_at, u);
			if (!rmii) exp_q.push_back(u);
			else if (i % 2) exp_q.push_back(pair_up(prev, u[1:0]));
			prev = u[1:0];
		end
		far.send(1'b0, 1'b0, ~u);
		repeat (40) @(negedge clk);
		if (bad_at < 0) begin
			chk(8'(got.size()), 8'(exp_q.size()));
			foreach (exp_q[i]) if (i < got.size()) chk(got[i], exp_q[i]);
		end
		chk(8'(drops), 8'(bad_at >= 0));
	endtask

	// One switch nibble outbound: low dibit first, each held a full strobe period
	task automatic drive_out(input logic [3:0] d);
		int n;
		logic [3:0] lo_e;
		logic [3:0] hi_e;
		lo_e = rmii ? {2'h0, d[1:0]} : d;
		hi_e = rmii ? {2'h0, d[3:2]} : d;
		n = 0;
		@(negedge clk);
		mac_tx = {1'b1, 1'b0, d};
		while (rxv !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		if (n >= 400) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, n, 400);
			failures++;
			summarize();
		end
		chk({3'h0, rxv, rxd}, {4'h1, lo_e});
		repeat (slow ? 5 : 1) @(negedge lclk);
		chk({3'h0, rxv, rxd}, {4'h1, lo_e});
		repeat (slow ? 6 : 1) @(negedge lclk);
		chk({3'h0, rxv, rxd}, {4'h1, hi_e});
		@(negedge clk);
		mac_tx = '0;
		repeat (slow ? 11 : 2) @(negedge lclk);
		chk({7'h00, rxv}, 8'h00);
	endtask

	task automatic summarize();
		$display("checks=%0d failures=%0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		mode = TPI_MII_PHY;
		{speed_100, half_duplex, mac_tx_busy, rmii, slow} = 5'b10000;
		mac_tx = '0;
		repeat (20) @(negedge clk);
		srst = 1'b0;
		for (int m = 0; m < 4; m++) begin
			mode = (m < 2) ? tpi_mode_t'(m) : TPI_RMII;
			rmii = m >= 2;
			speed_100 = m != 3;
			slow = m == 3;
			repeat (20) @(negedge clk);
			frame(8, -1);
			frame(6, 3);
			drive_out(4'($random(seed)));
			@(negedge clk);
			{half_duplex, mac_tx_busy} = 2'b11;
			repeat (4) far.send(1'b1, 1'b0, 4'h5);
			chk({colp, mac_col, crsp, mac_crs}, {2'b11, m != 1, 1'b1});
			@(negedge clk);
			half_duplex = 1'b0;
			repeat (4) far.send(1'b1, 1'b0, 4'h6);
			chk({colp, mac_col}, 2'b00);
			far.send(1'b0, 1'b0, 4'ha);
			@(negedge clk);
			mac_tx_busy = 1'b0;
			$display("mode step %0d done", m);
		end
		summarize();
	end
endmodule // tpi_port_tb

/* File: src/tpi_pkg.sv */
// Types for the third-port media interface
package tpi_pkg;
	typedef enum logic [1:0] {
		TPI_MII_PHY = 2'b00,
		TPI_MII_MAC = 2'b01,
		TPI_RMII = 2'b10
	} tpi_mode_t;
	typedef struct packed {
		logic en;
		logic err;
		logic [3:0] data;
	} tpi_nib_t;
	typedef enum logic [2:0] {
		TPI_IDLE = 3'b001,
		TPI_RECV = 3'b010,
		TPI_DROP = 3'b100
	} tpi_rx_st_t;
endpackage

/* File: src/tpi_port.sv */
// Third-port MII/RMII pin adapter between switch MAC and external pins
`timescale 1ns/10ps
`include "tpi_regs.svh"
module tpi_port (
	input wire logic clk,
	input wire logic srst,
	input wire tpi_pkg::tpi_mode_t mode,
	input wire logic speed_100,
	input wire logic half_duplex,
	input wire tpi_pkg::tpi_nib_t mac_tx,
	input wire logic mac_tx_busy,
	output tpi_pkg::tpi_nib_t mac_rx,
	output logic mac_rx_drop,
	output logic mac_col,
	output logic mac_crs,
	input wire logic sw_tx_enable_pin,
	input wire logic sw_tx_error_pin,
	input wire logic [3:0] sw_tx_data_pins,
	input wire logic sw_tx_clock_pin,
	output logic sw_rx_valid_pin,
	output logic [3:0] sw_rx_data_pins,
	input wire logic sw_rx_clock_pin,
	input wire logic sw_ref_clock_pin,
	output logic sw_collision_pin,
	output logic sw_carrier_pin
);
	import tpi_pkg::*;

	// Pins from outside: data, controls and three clocks
	logic [8:0] pin_q;
	logic [8:0] pin_rise;
	tpi_sync #(.W(9)) u_sync (
		.clk(clk),
		.srst(srst),
		.d({sw_ref_clock_pin, sw_rx_clock_pin, sw_tx_clock_pin, sw_tx_error_pin,
			sw_tx_enable_pin, sw_tx_data_pins}),
		.q(pin_q),
		.rise(pin_rise)
	);
	logic [3:0] in_data;
	logic in_en;
	logic in_err;
	logic txc_edge;
	logic rxc_edge;
	logic ref_edge;
	assign in_data = pin_q[3:0];
	assign in_en = pin_q[4];
	assign in_err = pin_q[5];
	assign txc_edge = pin_rise[6];
	assign rxc_edge = pin_rise[7];
	assign ref_edge = pin_rise[8];

	logic is_rmii;
	logic is_mac;
	assign is_rmii = (mode == TPI_RMII);
	assign is_mac = (mode == TPI_MII_MAC);

	// Sample strobe: MII clocks for inbound, reference divided for 10M RMII
	logic [3:0] div_r;
	logic ref_tick;
	always_ff @(posedge clk) begin
		if (srst) begin
			div_r <= 4'h0;
		end else if (ref_edge) begin
			div_r <= (div_r == 4'(`TPI_SLOW_DIV - 1)) ? 4'h0 : div_r + 4'h1;
		end
	end
	assign ref_tick = ref_edge && (speed_100 || div_r == 4'h0);
	logic in_stb;
	logic out_stb;
	// PHY role: MAC's tx clock times inbound; MAC role: PHY's rx clock on tx clock pin
	assign in_stb = is_rmii ? ref_tick : txc_edge;
	assign out_stb = is_rmii ? ref_tick : (is_mac ? rxc_edge : txc_edge);

	// Inbound path: dibits packed into nibbles in RMII, for one switch MAC only
	logic lo_half_r;
	logic [1:0] lo_dib_r;
	logic err_seen_r;
	tpi_rx_st_t st_r;
	logic in_use_err;
	// Error input marks frames to discard in every role; tied low where unused
	assign in_use_err = in_err;
	always_ff @(posedge clk) begin
		if (srst) begin
			st_r <= TPI_IDLE;
			lo_half_r <= 1'b0;
			lo_dib_r <= 2'b00;
			err_seen_r <= 1'b0;
			mac_rx <= '0;
			mac_rx_drop <= 1'b0;
		end else begin
			mac_rx.en <= 1'b0;
			mac_rx.err <= 1'b0;
			mac_rx_drop <= 1'b0;
			if (in_stb) begin
				case (st_r)
					TPI_IDLE: begin
						lo_half_r <= 1'b0;
						if (in_en) begin
							st_r <= TPI_RECV;
						end
					end
					TPI_RECV: begin
						if (!in_en) begin
							st_r <= TPI_IDLE;
							// Dropped frame flagged once at its end
							mac_rx_drop <= err_seen_r;
							err_seen_r <= 1'b0;
						end else if (in_use_err) begin
							err_seen_r <= 1'b1;
							st_r <= TPI_DROP;
						end
					end
					TPI_DROP: begin
						if (!in_en) begin
							st_r <= TPI_IDLE;
							mac_rx_drop <= 1'b1;
							err_seen_r <= 1'b0;
						end
					end
					default: st_r <= TPI_IDLE;
				endcase
				if (in_en && st_r != TPI_DROP && !in_use_err) begin
					if (is_rmii) begin
						// Upper pins ignored: may be tied low
						lo_dib_r <= in_data[1:0];
						lo_half_r <= ~lo_half_r;
						if (lo_half_r) begin
							mac_rx.en <= 1'b1;
							mac_rx.data <= {in_data[1:0], lo_dib_r};
						end
					end else begin
						mac_rx.en <= 1'b1;
						mac_rx.data <= in_data;
					end
				end
			end
		end
	end

	// Outbound path: switch nibbles to pins, split into dibits for RMII
	logic hi_half_r;
	always_ff @(posedge clk) begin
		if (srst) begin
			sw_rx_valid_pin <= 1'b0;
			sw_rx_data_pins <= 4'h0;
			hi_half_r <= 1'b0;
		end else if (out_stb) begin
			// Switch error is never forwarded as a pin
			sw_rx_valid_pin <= mac_tx.en;
			if (is_rmii) begin
				hi_half_r <= mac_tx.en ? ~hi_half_r : 1'b0;
				sw_rx_data_pins <= {2'b00, hi_half_r ? mac_tx.data[3:2] : mac_tx.data[1:0]};
			end else begin
				hi_half_r <= 1'b0;
				sw_rx_data_pins <= mac_tx.data;
			end
		end
	end

	// Carrier in either duplex mode, collision for half duplex only
	logic col_nxt;
	logic crs_nxt;
	assign crs_nxt = is_mac ? 1'b0 : (in_en | (is_rmii ? 1'b0 : mac_tx.en));
	assign col_nxt = half_duplex && in_en && (mac_tx.en || mac_tx_busy);
	always_ff @(posedge clk) begin
		if (srst) begin
			sw_collision_pin <= 1'b0;
			sw_carrier_pin <= 1'b0;
			mac_col <= 1'b0;
			mac_crs <= 1'b0;
		end else begin
			sw_collision_pin <= col_nxt;
			sw_carrier_pin <= crs_nxt;
			mac_col <= col_nxt;
			mac_crs <= in_en;
		end
	end

	a_col_cause: assert property (@(posedge clk) disable iff (srst)
		sw_collision_pin |-> $past(half_duplex && in_en))
		else $error("collision without cause");
	a_rx_valid: assert property (@(posedge clk) disable iff (srst)
		$changed(sw_rx_valid_pin) |-> $past(out_stb))
		else $error("rx valid moved off strobe");
	a_rmii_upper: assert property (@(posedge clk) disable iff (srst)
		(is_rmii && $past(is_rmii) && $past(out_stb)) |-> sw_rx_data_pins[3:2] == 2'b00)
		else $error("upper dibit not zero in rmii");
	a_drop_pulse: assert property (@(posedge clk) disable iff (srst)
		mac_rx_drop |=> !mac_rx_drop)
		else $error("drop not a pulse");
	a_drop_no_data: assert property (@(posedge clk) disable iff (srst)
		(st_r == TPI_DROP) |=> !mac_rx.en)
		else $error("data after error");
	a_slow_div: assert property (@(posedge clk) disable iff (srst)
		div_r <= 4'(`TPI_SLOW_DIV - 1))
		else $error("divider out of range");
	a_carrier_mac: assert property (@(posedge clk) disable iff (srst)
		(is_mac && $past(is_mac)) |-> !sw_carrier_pin)
		else $error("carrier in mac role");
	a_nibble_out: assert property (@(posedge clk) disable iff (srst)
		(out_stb && !is_rmii) |=> sw_rx_data_pins == $past(mac_tx.data))
		else $error("nibble not passed");
	c_rmii_frame: cover property (@(posedge clk) is_rmii && mac_rx.en);
	c_mii_frame: cover property (@(posedge clk) !is_rmii && mac_rx.en);
	c_drop: cover property (@(posedge clk) mac_rx_drop);
	c_col: cover property (@(posedge clk) sw_collision_pin);
endmodule // tpi_port

/* File: src/tpi_regs.svh */
// Timing counts and constants for the third-port media interface
`ifndef TPI_REGS_SVH
`define TPI_REGS_SVH
`define TPI_CLK_MHZ 100
`define TPI_REF_MHZ 50
`define TPI_SLOW_DIV 10
`define TPI_NIB_W 4
`define TPI_DIB_W 2
`define TPI_GAP_NS 960
`define TPI_GAP_CYC ((`TPI_GAP_NS * `TPI_CLK_MHZ + 999) / 1000)
`endif

/* File: src/tpi_sync.sv */
// Two-flop synchroniser with edge detection on the second stage
`timescale 1ns/10ps
module tpi_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q,
	output logic [W-1:0] rise
);
	logic [W-1:0] s1_r;
	logic [W-1:0] q_d_r;
	// First stage only feeds the second
	always_ff @(posedge clk) begin
		if (srst) begin
			s1_r <= '0;
			q <= '0;
			q_d_r <= '0;
		end else begin
			s1_r <= d;
			q <= s1_r;
			q_d_r <= q;
		end
	end
	assign rise = q & ~q_d_r;
endmodule // tpi_sync
